// ===== hdl/compare_branch_skip_unit.sv
// Compare, conditional skip, conditional branch, I/O bit set/clear and
// single-bit shift execution unit of an 8-bit core, driven over APB.
// Assumes an APB master on pclk; operands, flags, PC and I/O bank are registers.
//
// How it works
// - Compares subtract register, immediate or register plus carry; set Z,N,V,C,H only.
// - Register bit clear skip advances PC by 2 or 3; flags kept; 1/2/3 cycles.
// - Register bit set skip advances PC by 2 or 3; flags kept; 1/2/3 cycles.
// - I/O bit clear skip advances PC by 2 or 3; flags kept; 1/2/3 cycles.
// - I/O bit set skip advances PC by 2 or 3; flags kept; 1/2/3 cycles.
// - Generic flag branches test any flag by index; taken PC is PC+k+1.
// - Not-equal branches on Z zero, equal branches on Z one.
// - Carry set and lower branch on C one; carry clear and same-or-higher on zero.
// - Minus branches on N one, plus branches on N zero.
// - Signed greater-or-equal branches when N xor V is zero.
// - Signed less-than branches when N xor V is one; flags unchanged.
// - Half-carry branches test H one or zero.
// - Transfer-bit branches test T one or zero.
// - Overflow branches test V one or zero.
// - Interrupt-state branches test the global interrupt flag one or zero.
// - Set I/O bit forces one bit to one, others and flags kept, 2 cycles.
// - Clear I/O bit forces one bit to zero, others and flags kept, 2 cycles.
// - Left shift moves bits up, fills bit 0 with zero, sets Z,C,N,V, 1 cycle.
// - Right shift moves bits down, fills bit 7 with zero, sets Z,C,N,V, 1 cycle.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps

module compare_branch_skip_unit
(
  input wire logic pclk, // 50 MHz bus clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic busy // Instruction in execution
);

  logic [7:0] opa_q;
  logic [7:0] opb_q;
  logic [7:0] flags_q;
  logic [15:0] pc_q;
  logic [6:0] offset_q;
  logic [7:0] io_q [cbs_pkg::IO_COUNT];
  logic [11:0] cmd_q;
  cbs_pkg::state_type state_q;
  logic [1:0] cnt_q;
  logic [1:0] ncyc_q;
  logic taken_q;
  logic done_q;
  logic [31:0] prdata_q;

  logic access;
  logic mapped;
  logic cmd_refused;
  logic wr_en;
  logic start;
  logic apply;
  cbs_pkg::op_type op;
  logic [2:0] bit_sel;
  logic [cbs_pkg::IO_IDX_W-1:0] io_sel;
  logic [cbs_pkg::IO_IDX_W-1:0] wr_io_idx;
  logic [7:0] flags_d;
  logic [15:0] pc_d;
  logic [7:0] opa_d;
  logic opa_we;
  logic io_we;
  logic [7:0] io_d;
  logic taken_d;
  logic [1:0] ncyc_d;

  // Subtraction for compares: {h, v, n, z, c}
  function automatic logic [4:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
    logic [8:0] diff;
    logic [7:0] r;
    logic h;
    logic v;
    diff = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    r = diff[7:0];
    h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    sub_flags = {h, v, r[7], r == 8'h00, diff[8]};
  endfunction

  // Shift flags: {z, c, n, v} for a result and the bit shifted out
  function automatic logic [3:0] shift_flags(input logic [7:0] r, input logic out_bit);
    shift_flags = {r == 8'h00, out_bit, r[7], r[7] ^ out_bit};
  endfunction

  // Address decode
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= cbs_pkg::ADDR_STATUS ||
                  (a >= cbs_pkg::ADDR_IO_BASE && a <= cbs_pkg::ADDR_IO_LAST));
  endfunction

  assign access = psel & penable;
  assign mapped = addr_mapped(paddr);
  assign cmd_refused = pwrite && paddr == cbs_pkg::ADDR_CMD && state_q != cbs_pkg::st_idle;
  assign pready = 1'b1;
  assign pslverr = access & (~mapped | cmd_refused);
  assign wr_en = access & pwrite & mapped & ~cmd_refused;
  assign start = wr_en && paddr == cbs_pkg::ADDR_CMD;
  assign wr_io_idx = paddr[cbs_pkg::IO_IDX_W+1:2];
  assign prdata = prdata_q;
  assign busy = state_q == cbs_pkg::st_exec;

  assign op = cbs_pkg::op_type'(cmd_q[cbs_pkg::CMD_OP_LSB +: cbs_pkg::CMD_OP_W]);
  assign bit_sel = cmd_q[cbs_pkg::CMD_BIT_LSB +: 3];
  assign io_sel = cmd_q[cbs_pkg::CMD_IO_LSB +: cbs_pkg::IO_IDX_W];
  assign apply = busy && cnt_q == cbs_pkg::CYC_ONE;

  // Effects of the captured instruction
  always_comb
  begin
    logic [4:0] sf;
    logic [3:0] hf;
    logic [7:0] res;
    logic cond;
    logic is_branch;
    logic is_skip;
    logic [2:0] idx;
    logic want;
    sf = 5'h00;
    hf = 4'h0;
    res = opa_q;
    cond = 1'b0;
    is_branch = 1'b0;
    is_skip = 1'b0;
    idx = cbs_pkg::FLAG_Z;
    want = 1'b1;
    flags_d = flags_q;
    opa_we = 1'b0;
    opa_d = opa_q;
    io_we = 1'b0;
    io_d = io_q[io_sel];
    ncyc_d = cbs_pkg::CYC_ONE;
    case (op)
      cbs_pkg::compare_regs, cbs_pkg::compare_immediate, cbs_pkg::compare_regs_with_carry:
      begin
        sf = sub_flags(opa_q, opb_q,
                       op == cbs_pkg::compare_regs_with_carry && flags_q[cbs_pkg::FLAG_C]);
        flags_d[cbs_pkg::FLAG_H] = sf[4];
        flags_d[cbs_pkg::FLAG_V] = sf[3];
        flags_d[cbs_pkg::FLAG_N] = sf[2];
        flags_d[cbs_pkg::FLAG_Z] = sf[1];
        flags_d[cbs_pkg::FLAG_C] = sf[0];
      end
      cbs_pkg::skip_reg_bit_clear:
      begin
        is_skip = 1'b1;
        cond = ~opa_q[bit_sel];
      end
      cbs_pkg::skip_reg_bit_set:
      begin
        is_skip = 1'b1;
        cond = opa_q[bit_sel];
      end
      cbs_pkg::skip_io_bit_clear:
      begin
        is_skip = 1'b1;
        cond = ~io_q[io_sel][bit_sel];
      end
      cbs_pkg::skip_io_bit_set:
      begin
        is_skip = 1'b1;
        cond = io_q[io_sel][bit_sel];
      end
      cbs_pkg::branch_flag_set, cbs_pkg::branch_flag_clear:
      begin
        is_branch = 1'b1;
        idx = bit_sel;
        want = op == cbs_pkg::branch_flag_set;
      end
      cbs_pkg::branch_equal, cbs_pkg::branch_not_equal:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_Z;
        want = op == cbs_pkg::branch_equal;
      end
      cbs_pkg::branch_carry_set, cbs_pkg::branch_lower,
      cbs_pkg::branch_carry_clear, cbs_pkg::branch_same_or_higher:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_C;
        want = op == cbs_pkg::branch_carry_set || op == cbs_pkg::branch_lower;
      end
      cbs_pkg::branch_minus, cbs_pkg::branch_plus:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_N;
        want = op == cbs_pkg::branch_minus;
      end
      cbs_pkg::branch_halfcarry_set, cbs_pkg::branch_halfcarry_clear:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_H;
        want = op == cbs_pkg::branch_halfcarry_set;
      end
      cbs_pkg::branch_transfer_bit_set, cbs_pkg::branch_transfer_bit_clear:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_T;
        want = op == cbs_pkg::branch_transfer_bit_set;
      end
      cbs_pkg::branch_overflow_set, cbs_pkg::branch_overflow_clear:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_V;
        want = op == cbs_pkg::branch_overflow_set;
      end
      cbs_pkg::branch_irq_enabled, cbs_pkg::branch_irq_disabled:
      begin
        is_branch = 1'b1;
        idx = cbs_pkg::FLAG_I;
        want = op == cbs_pkg::branch_irq_enabled;
      end
      cbs_pkg::branch_signed_ge:
        cond = (flags_q[cbs_pkg::FLAG_N] ^ flags_q[cbs_pkg::FLAG_V]) == 1'b0;
      cbs_pkg::branch_signed_lt:
        cond = (flags_q[cbs_pkg::FLAG_N] ^ flags_q[cbs_pkg::FLAG_V]) == 1'b1;
      cbs_pkg::set_io_bit, cbs_pkg::clear_io_bit:
      begin
        io_we = 1'b1;
        io_d[bit_sel] = op == cbs_pkg::set_io_bit;
        ncyc_d = cbs_pkg::CYC_TWO;
      end
      cbs_pkg::shift_left_logical:
      begin
        res = {opa_q[6:0], 1'b0};
        hf = shift_flags(res, opa_q[7]);
        opa_we = 1'b1;
      end
      cbs_pkg::shift_right_logical:
      begin
        res = {1'b0, opa_q[7:1]};
        hf = shift_flags(res, opa_q[0]);
        opa_we = 1'b1;
      end
      default:
        ncyc_d = cbs_pkg::CYC_ONE;
    endcase
    if (is_branch)
      cond = flags_q[idx] == want;
    if (opa_we)
    begin
      opa_d = res;
      flags_d[cbs_pkg::FLAG_Z] = hf[3];
      flags_d[cbs_pkg::FLAG_C] = hf[2];
      flags_d[cbs_pkg::FLAG_N] = hf[1];
      flags_d[cbs_pkg::FLAG_V] = hf[0];
    end
    taken_d = cond;
    pc_d = pc_q + 16'h0001;
    if (is_skip && cond)
    begin
      pc_d = pc_q + (cmd_q[cbs_pkg::CMD_TWO_WORD] ? 16'h0003 : 16'h0002);
      ncyc_d = cmd_q[cbs_pkg::CMD_TWO_WORD] ? cbs_pkg::CYC_THREE : cbs_pkg::CYC_TWO;
    end
    else if (cond)
    begin
      pc_d = pc_q + {{9{offset_q[6]}}, offset_q} + 16'h0001;
      ncyc_d = cbs_pkg::CYC_TWO;
    end
  end

  // Command capture and cycle sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= cbs_pkg::st_idle;
      cmd_q <= 12'h01F;
      cnt_q <= 2'h0;
      ncyc_q <= 2'h0;
      taken_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        cbs_pkg::st_idle:
        begin
          if (start)
          begin
            cmd_q <= pwdata[11:0];
            cnt_q <= cbs_pkg::CYC_ONE;
            state_q <= cbs_pkg::st_exec;
          end
        end
        cbs_pkg::st_exec:
        begin
          if (apply)
          begin
            ncyc_q <= ncyc_d;
            taken_q <= taken_d;
          end
          if ((apply ? ncyc_d : ncyc_q) == cnt_q)
          begin
            state_q <= cbs_pkg::st_idle;
            cnt_q <= 2'h0;
          end
          else
            cnt_q <= cnt_q + 2'h1;
        end
        default:
          state_q <= cbs_pkg::st_idle;
      endcase
    end
  end

  // Done flag: completion wins over a clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_q <= 1'b0;
    else if (busy && (apply ? ncyc_d : ncyc_q) == cnt_q)
      done_q <= 1'b1;
    else if (wr_en && paddr == cbs_pkg::ADDR_STATUS && pwdata[cbs_pkg::STAT_DONE])
      done_q <= 1'b0;
    else if (start)
      done_q <= 1'b0;
  end

  // Operand, flag, PC and offset registers; execution takes priority
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      opa_q <= cbs_pkg::BYTE_RST;
      opb_q <= cbs_pkg::BYTE_RST;
      flags_q <= cbs_pkg::FLAGS_RST;
      pc_q <= cbs_pkg::PC_RST;
      offset_q <= cbs_pkg::OFFSET_RST;
    end
    else if (apply)
    begin
      flags_q <= flags_d;
      pc_q <= pc_d;
      opa_q <= opa_d;
    end
    else if (wr_en)
    begin
      case (paddr)
        cbs_pkg::ADDR_OPA: opa_q <= pwdata[7:0];
        cbs_pkg::ADDR_OPB: opb_q <= pwdata[7:0];
        cbs_pkg::ADDR_FLAGS: flags_q <= pwdata[7:0];
        cbs_pkg::ADDR_PC: pc_q <= pwdata[15:0];
        cbs_pkg::ADDR_OFFSET: offset_q <= pwdata[6:0];
        default: offset_q <= offset_q;
      endcase
    end
  end

  // I/O register bank
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < cbs_pkg::IO_COUNT; i++)
        io_q[i] <= cbs_pkg::BYTE_RST;
    else if (apply && io_we)
      io_q[io_sel] <= io_d;
    else if (wr_en && paddr >= cbs_pkg::ADDR_IO_BASE)
      io_q[wr_io_idx] <= pwdata[7:0];
  end

  // Read data registered in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= 32'h00000000;
      if (paddr >= cbs_pkg::ADDR_IO_BASE && addr_mapped(paddr))
        prdata_q <= {24'h000000, io_q[wr_io_idx]};
      else
        case (paddr)
          cbs_pkg::ADDR_CMD: prdata_q <= {20'h00000, cmd_q};
          cbs_pkg::ADDR_OPA: prdata_q <= {24'h000000, opa_q};
          cbs_pkg::ADDR_OPB: prdata_q <= {24'h000000, opb_q};
          cbs_pkg::ADDR_FLAGS: prdata_q <= {24'h000000, flags_q};
          cbs_pkg::ADDR_PC: prdata_q <= {16'h0000, pc_q};
          cbs_pkg::ADDR_OFFSET: prdata_q <= {25'h0000000, offset_q};
          cbs_pkg::ADDR_STATUS: prdata_q <= {27'h0000000, ncyc_q, taken_q, done_q, busy};
          default: prdata_q <= 32'h00000000;
        endcase
    end
  end

endmodule

// ===== shared/cbs_pkg.sv
// Constants, field layout and encodings of the compare, branch and skip unit.
// Shared by the design and by the verification side; nothing here has state.
package cbs_pkg;

  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OPA = 8'h04;
  localparam logic [7:0] ADDR_OPB = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IO_BASE = 8'h20;
  localparam logic [7:0] ADDR_IO_LAST = 8'h3C;

  // I/O register bank
  localparam int IO_COUNT = 8;
  localparam int IO_IDX_W = 3;

  // Status flag bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 5;
  localparam int CMD_BIT_LSB = 5;
  localparam int CMD_IO_LSB = 8;
  localparam int CMD_TWO_WORD = 11;

  // Status register bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_TAKEN = 2;
  localparam int STAT_CYC_LSB = 3;

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [6:0] OFFSET_RST = 7'h00;

  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [CMD_OP_W-1:0] {
    compare_regs, compare_regs_with_carry, compare_immediate,
    skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear, branch_equal, branch_not_equal,
    branch_carry_set, branch_carry_clear, branch_same_or_higher, branch_lower,
    branch_minus, branch_plus, branch_signed_ge, branch_signed_lt,
    branch_halfcarry_set, branch_halfcarry_clear, branch_transfer_bit_set,
    branch_transfer_bit_clear, branch_overflow_set, branch_overflow_clear,
    branch_irq_enabled, branch_irq_disabled, set_io_bit, clear_io_bit,
    shift_left_logical, shift_right_logical, op_none
  } op_type;

  typedef enum logic {st_idle, st_exec} state_type;

endpackage

// ===== bench/compare_branch_skip_unit_monitor.sv
// Checker for the compare, branch and skip unit, bound to its ports.
// Assumes one clock domain, pclk, and the asynchronous active-low presetn.
`timescale 1ns/100ps
module compare_branch_skip_unit_monitor
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic busy // Execution in progress
);
  logic go;
  logic [4:0] op;
  assign go = psel && penable && pwrite && paddr == cbs_pkg::ADDR_CMD && !busy;
  assign op = pwdata[4:0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  cmd_start_a: assert property (go |=> busy) else $error("command did not start");
  single_cycle_a: assert property (go && (op <= 5'h02 || op >= 5'h1D) |=> busy ##1 !busy)
    else $error("one-cycle op length wrong");
  io_bit_len_a: assert property (go && (op == 5'h1B || op == 5'h1C) |=> busy [*2] ##1 !busy)
    else $error("io bit op length wrong");
  branch_len_a: assert property (go && op >= 5'h07 && op <= 5'h1A
    |=> busy ##1 (!busy or (busy ##1 !busy))) else $error("branch length wrong");
  skip_short_a: assert property (go && op >= 5'h03 && op <= 5'h06 && !pwdata[11]
    |=> busy ##1 (!busy or (busy ##1 !busy))) else $error("short skip length wrong");
  skip_long_a: assert property (go && op >= 5'h03 && op <= 5'h06 && pwdata[11]
    |=> busy ##1 (!busy or (busy [*2] ##1 !busy))) else $error("long skip length wrong");
  busy_cause_a: assert property ($rose(busy) |-> $past(go)) else $error("busy without command");
  busy_refuse_a: assert property (psel && penable && pwrite && paddr == cbs_pkg::ADDR_CMD && busy
    |-> pslverr) else $error("command while busy accepted");
  unmapped_err_a: assert property (psel && penable && paddr == 8'h1C
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule

bind compare_branch_skip_unit compare_branch_skip_unit_monitor mon_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// ===== bench/compare_branch_skip_unit_tb_top.sv
// Self-checking bench for the compare, branch and skip unit over APB.
// Assumes zero-wait APB slave; results are read back through registers.
`timescale 1ns/100ps
module compare_branch_skip_unit_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, e, t;
  logic [7:0] paddr;
  logic [15:0] x;
  logic [31:0] pwdata, prdata, q, r_pc, r_fl, r_a, r_st, r_io;
  logic [7:0] fv [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
  logic [7:0] av [4] = '{8'h10, 8'h00, 8'h80, 8'h7F};
  logic [7:0] bv [4] = '{8'h10, 8'h01, 8'h01, 8'hFF};
  int errors = 0;
  int samples_checked = 0;

  compare_branch_skip_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] g);
    samples_checked++;
    if (g !== xp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, xp, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic cond(input logic [4:0] op, input logic [7:0] f, input logic [2:0] b);
    logic v;
    logic inv;
    case (op)
      5'h07, 5'h08: v = f[b];
      5'h09, 5'h0A: v = f[cbs_pkg::FLAG_Z];
      5'h0B, 5'h0C, 5'h0D, 5'h0E: v = f[cbs_pkg::FLAG_C];
      5'h0F, 5'h10: v = f[cbs_pkg::FLAG_N];
      5'h11, 5'h12: v = f[cbs_pkg::FLAG_N] ^ f[cbs_pkg::FLAG_V];
      5'h13, 5'h14: v = f[cbs_pkg::FLAG_H];
      5'h15, 5'h16: v = f[cbs_pkg::FLAG_T];
      5'h17, 5'h18: v = f[cbs_pkg::FLAG_V];
      default: v = f[cbs_pkg::FLAG_I];
    endcase
    // Odd codes branch on one, except same-or-higher and signed greater-or-equal
    inv = op inside {5'h0D, 5'h0E, 5'h11, 5'h12};
    return (op[0] ^ inv) ? v : ~v;
  endfunction

  function automatic logic [7:0] cmp_fl(input logic [7:0] a, b, f, input logic ci);
    logic [8:0] d;
    logic [7:0] o;
    d = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    o = f;
    o[cbs_pkg::FLAG_C] = d[8];
    o[cbs_pkg::FLAG_Z] = d[7:0] == 8'h00;
    o[cbs_pkg::FLAG_N] = d[7];
    o[cbs_pkg::FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
    o[cbs_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
    return o;
  endfunction

  function automatic logic [15:0] shf(input logic [7:0] a, f, input logic rt);
    logic [7:0] r;
    logic [7:0] o;
    r = rt ? {1'b0, a[7:1]} : {a[6:0], 1'b0};
    o = f;
    o[cbs_pkg::FLAG_C] = rt ? a[0] : a[7];
    o[cbs_pkg::FLAG_Z] = r == 8'h00;
    o[cbs_pkg::FLAG_N] = r[7];
    o[cbs_pkg::FLAG_V] = r[7] ^ o[cbs_pkg::FLAG_C];
    return {o, r};
  endfunction

  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic two,
    input logic [7:0] fl, input logic [7:0] a, input logic [7:0] k, input logic poke);
    logic [7:0] io;
    io = cbs_pkg::ADDR_IO_BASE + {3'h0, b, 2'h0};
    apb(1'b1, cbs_pkg::ADDR_PC, 32'h0000_0100);
    apb(1'b1, cbs_pkg::ADDR_OFFSET, 32'h0000_007E);
    apb(1'b1, cbs_pkg::ADDR_FLAGS, {24'h0, fl});
    apb(1'b1, cbs_pkg::ADDR_OPA, {24'h0, a});
    apb(1'b1, cbs_pkg::ADDR_OPB, {24'h0, k});
    apb(1'b1, io, {24'h0, a});
    apb(1'b1, cbs_pkg::ADDR_CMD, {20'h0, two, b, b, op});
    if (poke)
    begin
      apb(1'b1, cbs_pkg::ADDR_CMD, 32'h0000_001F);
      chk("cmd while busy", 32'h1, {31'h0, e});
    end
    for (int n = 0; n < 8; n++)
    begin
      @(posedge pclk);
      #1;
      if (busy === 1'b0)
        break;
    end
    chk("busy", 32'h0, {31'h0, busy});
    apb(1'b0, cbs_pkg::ADDR_PC, 32'h0);
    r_pc = q;
    apb(1'b0, cbs_pkg::ADDR_FLAGS, 32'h0);
    r_fl = q;
    apb(1'b0, cbs_pkg::ADDR_OPA, 32'h0);
    r_a = q;
    apb(1'b0, cbs_pkg::ADDR_STATUS, 32'h0);
    r_st = q;
    apb(1'b0, io, 32'h0);
    r_io = q;
  endtask

  task automatic ck(input logic [15:0] pc, input logic [7:0] fl, input logic [1:0] cy);
    chk("pc", {16'h0, pc}, r_pc);
    chk("flags", {24'h0, fl}, r_fl);
    chk("status", {27'h0, cy, 1'b0, 2'h2}, r_st & 32'h0000_001B);
  endtask

  initial
  begin
    #400000;
    errors++;
    end_sim();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 1; j < 16; j++)
    begin
      apb(1'b0, {j[5:0], 2'h0}, 32'h0);
      chk("reset value", 32'h0, q);
      chk("addr error", {31'h0, j == 7}, {31'h0, e});
    end
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned", 32'h1, {31'h0, e});
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk("unmapped write", 32'h1, {31'h0, e});
    for (int o = 7; o <= 26; o++)
      for (int j = 0; j < 4; j++)
      begin
        run(o[4:0], o[2:0] ^ j[2:0], 1'b0, fv[j], 8'h00, 8'h00, 1'b0);
        t = cond(o[4:0], fv[j], o[2:0] ^ j[2:0]);
        ck(t ? 16'h00FF : 16'h0101, fv[j], t ? 2'h2 : 2'h1);
        chk("taken", {31'h0, t}, {31'h0, r_st[2]});
      end
    for (int o = 3; o <= 6; o++)
      for (int j = 0; j < 16; j++)
      begin
        run(o[4:0], j[2:0], j[3], 8'h3C, 8'hA5, 8'h00, 1'b0);
        t = ((8'hA5 >> j[2:0]) & 8'h01) != 8'h00;
        t = t ^ o[0];
        ck(t ? 16'h0102 + j[3] : 16'h0101, 8'h3C, t ? 2'h2 + j[3] : 2'h1);
        chk("skipped", {31'h0, t}, {31'h0, r_st[2]});
      end
    for (int o = 0; o <= 2; o++)
      for (int j = 0; j < 4; j++)
      begin
        run(o[4:0], 3'h0, 1'b0, fv[j], av[j], bv[j], 1'b0);
        ck(16'h0101, cmp_fl(av[j], bv[j], fv[j], o == 1 && fv[j][0]), 2'h1);
        chk("compare opa", {24'h0, av[j]}, r_a);
      end
    for (int j = 0; j < 8; j++)
    begin
      run(j[0] ? 5'h1E : 5'h1D, 3'h0, 1'b0, fv[j[2:1]], av[j[2:1]], 8'h00, 1'b0);
      x = shf(av[j[2:1]], fv[j[2:1]], j[0]);
      ck(16'h0101, x[15:8], 2'h1);
      chk("shift result", {24'h0, x[7:0]}, r_a);
    end
    for (int j = 0; j < 16; j++)
    begin
      run(j[3] ? 5'h1C : 5'h1B, j[2:0], 1'b0, 8'h96, 8'h5A, 8'h00, 1'b0);
      ck(16'h0101, 8'h96, 2'h2);
      x[7:0] = j[3] ? 8'h5A & ~(8'h01 << j[2:0]) : 8'h5A | (8'h01 << j[2:0]);
      chk("io bit", {24'h0, x[7:0]}, r_io);
    end
    run(5'h1F, 3'h0, 1'b0, 8'h3C, 8'h5A, 8'h00, 1'b0);
    ck(16'h0101, 8'h3C, 2'h1);
    chk("idle op opa", 32'h5A, r_a);
    run(5'h03, 3'h1, 1'b1, 8'h00, 8'h00, 8'h00, 1'b1);
    ck(16'h0103, 8'h00, 2'h3);
    apb(1'b1, cbs_pkg::ADDR_STATUS, 32'h0000_0002);
    apb(1'b0, cbs_pkg::ADDR_STATUS, 32'h0);
    chk("done cleared", 32'h0, {31'h0, q[1]});
    end_sim();
  end
endmodule
